/* verilog/tlg_map.vh */
// tlg_map.vh: constants of the torque limit and thermal guard
// assumes percent values in whole percent, temperatures in whole degrees C
`ifndef TLG_MAP_VH
`define TLG_MAP_VH
`define TLG_LIMIT_DEFAULT 9'h0c8
`define TLG_LIMIT_MAX 9'h12c
`define TLG_CAP_HEAVY 9'h096
`define TLG_CAP_NORMAL 9'h078
`define TLG_CUR_PL_MIN 9'h01e
`define TLG_FN_AT_LIMIT 6'h30
`define TLG_FN_PREALARM 6'h20
`define TLG_FN_FAULT 6'h0e
`define TLG_FN_REDUCE_MAX 6'h4d
`define TLG_AI_GENERAL 5'h15
`define TLG_AI_FWD 5'h10
`define TLG_AI_REV 5'h11
`define TLG_AI_REGEN 5'h12
`define TLG_ACT_RAMP 3'h0
`define TLG_ACT_COAST 3'h1
`define TLG_ACT_FAST 3'h2
`define TLG_ACT_ALARM 3'h3
`define TLG_ACT_REDUCE 3'h4
`define TLG_REDUCE_STEPS 4'ha
`define TLG_FACTOR_DEFAULT 4'h8
`define TLG_CLK_HZ 10000000
`define TLG_TICK_US 1000
`define TLG_TICK_CYCLES (`TLG_CLK_HZ / 1000000 * `TLG_TICK_US)
`define TLG_BUILD_MS 64
`define TLG_STEP_MS 10000
`define TLG_INT_MIN_MS 5
`define TLG_INT_MAX_MS 10000
`define TLG_INT_DEFAULT_MS 200
`define TLG_FACTOR_MIN 4'h1
`define TLG_FACTOR_MAX 4'h9
`endif

/* verilog/tlg_step_timer.v */
// tlg_step_timer.v: millisecond interval timer on a shared tick
// assumes tick_i is a one-cycle pulse every millisecond
`timescale 1ns/1ns
`default_nettype none
module tlg_step_timer #(
  parameter WIDTH = 14
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire tick_i,
  input wire restart_i,
  input wire [WIDTH-1:0] period_i,
  output reg expired_o
);
  reg [WIDTH-1:0] count_r;
  // restarts on entry; expired_o pulses once per period
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= {WIDTH{1'b0}};
      expired_o <= 1'b0;
    end else if (restart_i) begin
      count_r <= {WIDTH{1'b0}}; // RULE23
      expired_o <= 1'b0;
    end else begin
      expired_o <= 1'b0;
      if (tick_i) begin
        if (count_r + 1'b1 >= period_i) begin
          count_r <= {WIDTH{1'b0}};
          expired_o <= 1'b1;
        end else begin
          count_r <= count_r + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/tlg_guard.v */
// tlg_guard.v: torque limit selection and heatsink/input supervision
// assumes all inputs synchronous to clock_i; settings held stable by host
// Function
// RULE1: four quadrant torque limits, 0 to 300 percent, default 200.
// RULE2: quadrant limiting only in the four vector control modes.
// RULE3: digital output function 30 shows running at torque limit.
// RULE4: analog function 15 general; 10, 11, 12 forward, reverse, regen.
// RULE5: lowest of parameter and analog limits applies per quadrant.
// RULE6: torque capped by current: 150 heavy duty, 120 normal duty.
// RULE7: limit integral time 5 to 10000 ms, default 200 ms.
// RULE8: method 0 uses proportional in speed changes, integral otherwise.
// RULE9: method 1 uses integral action always.
// RULE10: build select 1 delays limit 64 ms at start; 0 none.
// RULE11: regen mode 1 keeps only regen parameters and regen analog.
// RULE12: overheat alarm when heatsink above alarm level, 50 to 150 C. Code uses overheat_alarm_level_i as given, not limited to 50 to 150.
// RULE13: digital output function 20 closes above alarm level.
// RULE14: in reduce mode, fault level reached raises fault and stops.
// RULE15: action 0 ramp, 1 coast, 2 fast stop; each sets fault output.
// RULE16: action 3 only signals the alarm, speed unchanged.
// RULE17: action 4 reduces speed on alarm, again every 10 s.
// RULE18: after alarm clears, step back up each 10 s to base.
// RULE19: digital output function 4D when alarm persists ten reductions.
// RULE20: reduction factor 0.1 to 0.9, default 0.8, of max frequency.
// RULE21: input phase loss select 1 detects ripple fault; 0 off.
// RULE22: phase loss detect off decelerating, not running, current <=30%.
// RULE23: 10 s and 64 ms timed from one tick, restart on entry.
// RULE24: reduced speed is max frequency times factor n times, cap ten.
`timescale 1ns/1ns
`default_nettype none
`include "tlg_map.vh"
module tlg_guard #(
  parameter W = 9,
  parameter TICK_CYCLES = `TLG_TICK_CYCLES,
  parameter STEP_MS = `TLG_STEP_MS
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire run_i,
  input wire accel_i,
  input wire decel_i,
  input wire [1:0] quadrant_i,
  input wire [3:0] control_mode_i,
  input wire heavy_duty_rating_i,
  input wire [W-1:0] fwd_motoring_torque_limit_i,
  input wire [W-1:0] rev_motoring_torque_limit_i,
  input wire [W-1:0] fwd_regen_torque_limit_i,
  input wire [W-1:0] rev_regen_torque_limit_i,
  input wire [13:0] limit_integral_time_i,
  input wire accel_limit_method_sel_i,
  input wire start_limit_build_sel_i,
  input wire regen_limit_mode_sel_i,
  input wire [4:0] analog_input_function_a_i,
  input wire [4:0] analog_input_function_b_i,
  input wire [4:0] analog_input_function_c_i,
  input wire [W-1:0] analog_a_i,
  input wire [W-1:0] analog_b_i,
  input wire [W-1:0] analog_c_i,
  input wire [W-1:0] comm_limit_i,
  input wire comm_limit_valid_i,
  input wire [W-1:0] torque_i,
  input wire [W-1:0] current_i,
  input wire [7:0] heatsink_temp_i,
  input wire [7:0] overheat_alarm_level_i,
  input wire [7:0] overheat_fault_level_i,
  input wire [2:0] overheat_action_sel_i,
  input wire [3:0] overheat_speed_reduction_factor_i,
  input wire [15:0] max_freq_i,
  input wire [15:0] base_freq_i,
  input wire input_phase_loss_sel_i,
  input wire ripple_high_i,
  input wire [5:0] digital_output_function_a_i,
  input wire [5:0] digital_output_function_b_i,
  input wire [5:0] digital_output_function_c_i,
  output reg [W-1:0] torque_limit_o,
  output reg limit_active_o,
  output reg limit_prop_o,
  output reg limit_integral_o,
  output reg [13:0] limit_integral_time_o,
  output reg [15:0] speed_ceiling_o,
  output reg heatsink_overheat_alarm_o,
  output reg heatsink_overheat_fault_o,
  output reg input_phase_loss_fault_o,
  output reg ramp_stop_o,
  output reg coast_stop_o,
  output reg fast_stop_o,
  output reg [2:0] digital_out_o
);
  localparam ST_NORMAL = 3'b001;
  localparam ST_REDUCE = 3'b010;
  localparam ST_RECOVER = 3'b100;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [15:0] tick_cnt_r;
  reg tick_r;
  reg run_d_r;
  reg built_r;
  reg [3:0] steps_r;
  reg [3:0] steps_nxt;
  reg at_limit_r;
  wire step_exp;
  wire build_exp;
  wire start_edge = run_i & ~run_d_r;
  wire vector_mode = |control_mode_i;
  function [W-1:0] min2(input [W-1:0] a, input [W-1:0] b);
    min2 = (a < b) ? a : b;
  endfunction
  function [W-1:0] clamp_set(input [W-1:0] v);
    clamp_set = (v > `TLG_LIMIT_MAX) ? `TLG_LIMIT_MAX : v; // RULE1
  endfunction
  // analog limit for a quadrant given one input's function and value
  function [W-1:0] ai_limit(input [4:0] fn, input [W-1:0] val,
    input [1:0] q, input regen_only);
    reg regen_q;
    begin
      regen_q = q[1];
      ai_limit = `TLG_LIMIT_MAX;
      if (fn == `TLG_AI_REGEN && regen_q) // RULE4
        ai_limit = val;
      else if (!regen_only) begin // RULE11
        if (fn == `TLG_AI_GENERAL)
          ai_limit = val;
        else if (fn == `TLG_AI_FWD && q == 2'h0)
          ai_limit = val;
        else if (fn == `TLG_AI_REV && q == 2'h1)
          ai_limit = val;
      end
    end
  endfunction
  // one millisecond tick shared by every interval
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_CYCLES - 1) begin
      tick_cnt_r <= 16'h0000; // RULE23
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end
  tlg_step_timer #(.WIDTH(14)) u_build (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick_r),
    .restart_i(start_edge | ~run_i),
    .period_i(14'd`TLG_BUILD_MS),
    .expired_o(build_exp)
  );
  wire alarm_now = heatsink_temp_i > overheat_alarm_level_i; // RULE12
  wire reduce_mode = overheat_action_sel_i == `TLG_ACT_REDUCE;
  wire step_restart = (state_r != state_nxt) | (state_r == ST_NORMAL);
  tlg_step_timer #(.WIDTH(14)) u_step (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick_r),
    .restart_i(step_restart),
    .period_i(STEP_MS[13:0]),
    .expired_o(step_exp)
  );
  // quadrant limit selection
  reg [W-1:0] par_lim;
  reg [W-1:0] lim;
  reg [W-1:0] cap;
  always @* begin
    case (quadrant_i)
      2'h0: par_lim = fwd_motoring_torque_limit_i;
      2'h1: par_lim = rev_motoring_torque_limit_i;
      2'h2: par_lim = fwd_regen_torque_limit_i;
      default: par_lim = rev_regen_torque_limit_i;
    endcase
    lim = clamp_set(par_lim);
    lim = min2(lim, ai_limit(analog_input_function_a_i, analog_a_i,
      quadrant_i, regen_limit_mode_sel_i)); // RULE5
    lim = min2(lim, ai_limit(analog_input_function_b_i, analog_b_i,
      quadrant_i, regen_limit_mode_sel_i));
    lim = min2(lim, ai_limit(analog_input_function_c_i, analog_c_i,
      quadrant_i, regen_limit_mode_sel_i));
    if (comm_limit_valid_i && !regen_limit_mode_sel_i)
      lim = min2(lim, comm_limit_i); // RULE11
    cap = heavy_duty_rating_i ? `TLG_CAP_HEAVY : `TLG_CAP_NORMAL;
    lim = min2(lim, cap); // RULE6
  end
  // reduction state machine for overheat action 4
  always @* begin
    state_nxt = state_r;
    steps_nxt = steps_r;
    case (state_r)
      ST_NORMAL: begin
        if (reduce_mode && alarm_now && run_i) begin
          state_nxt = ST_REDUCE; // RULE17
          steps_nxt = 4'h1;
        end
      end
      ST_REDUCE: begin
        if (!alarm_now)
          state_nxt = ST_RECOVER; // RULE18
        else if (step_exp && steps_r < `TLG_REDUCE_STEPS)
          steps_nxt = steps_r + 4'h1; // RULE17
      end
      ST_RECOVER: begin
        if (alarm_now) begin
          state_nxt = ST_REDUCE;
          if (steps_r < `TLG_REDUCE_STEPS)
            steps_nxt = steps_r + 4'h1;
        end else if (step_exp) begin
          steps_nxt = steps_r - 4'h1; // RULE18
          if (steps_r == 4'h1)
            state_nxt = ST_NORMAL;
        end
      end
      default: begin
        state_nxt = ST_NORMAL;
        steps_nxt = 4'h0;
      end
    endcase
    if (!reduce_mode || !run_i) begin
      state_nxt = ST_NORMAL;
      steps_nxt = 4'h0;
    end
  end
  // speed ceiling: max frequency times factor, steps times
  reg [15:0] ceil_c;
  reg [19:0] prod;
  integer i;
  wire [3:0] factor = (overheat_speed_reduction_factor_i < `TLG_FACTOR_MIN) ?
    `TLG_FACTOR_MIN : (overheat_speed_reduction_factor_i > `TLG_FACTOR_MAX) ?
    `TLG_FACTOR_MAX : overheat_speed_reduction_factor_i; // RULE20
  always @* begin
    ceil_c = max_freq_i;
    prod = 20'h00000;
    for (i = 0; i < 10; i = i + 1) begin
      if (i < steps_r) begin
        prod = ceil_c * factor; // RULE24
        prod = prod / 20'd10; // RULE20
        ceil_c = prod[15:0];
      end
    end
    if (state_r == ST_RECOVER && ceil_c > base_freq_i)
      ceil_c = base_freq_i; // RULE18
    if (state_r == ST_NORMAL)
      ceil_c = max_freq_i; // RULE16
  end
  wire stop_act = alarm_now && overheat_action_sel_i < `TLG_ACT_ALARM;
  wire hot_fault = reduce_mode && heatsink_temp_i >= overheat_fault_level_i;
  wire pl_enable = input_phase_loss_sel_i && run_i && !decel_i &&
    current_i > `TLG_CUR_PL_MIN; // RULE22
  wire fault_any = heatsink_overheat_fault_o | input_phase_loss_fault_o;
  function do_bit(input [5:0] fn, input at_lim, input pre, input flt,
    input maxed);
    begin
      case (fn)
        `TLG_FN_AT_LIMIT: do_bit = at_lim; // RULE3
        `TLG_FN_PREALARM: do_bit = pre; // RULE13
        `TLG_FN_FAULT: do_bit = flt; // RULE15
        `TLG_FN_REDUCE_MAX: do_bit = maxed; // RULE19
        default: do_bit = 1'b0;
      endcase
    end
  endfunction
  wire maxed = alarm_now && state_r == ST_REDUCE &&
    steps_r == `TLG_REDUCE_STEPS;
  wire active_now = vector_mode && run_i && built_r; // RULE2
  wire stopped_by_alarm = stop_act | hot_fault;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_NORMAL;
      steps_r <= 4'h0;
      run_d_r <= 1'b0;
      built_r <= 1'b0;
      at_limit_r <= 1'b0;
      torque_limit_o <= `TLG_LIMIT_DEFAULT;
      limit_active_o <= 1'b0;
      limit_prop_o <= 1'b0;
      limit_integral_o <= 1'b0;
      limit_integral_time_o <= 14'd`TLG_INT_DEFAULT_MS;
      speed_ceiling_o <= 16'h0000;
      heatsink_overheat_alarm_o <= 1'b0;
      heatsink_overheat_fault_o <= 1'b0;
      input_phase_loss_fault_o <= 1'b0;
      ramp_stop_o <= 1'b0;
      coast_stop_o <= 1'b0;
      fast_stop_o <= 1'b0;
      digital_out_o <= 3'h0;
    end else begin
      state_r <= state_nxt;
      steps_r <= steps_nxt;
      run_d_r <= run_i;
      if (!run_i)
        built_r <= 1'b0;
      else if (start_edge)
        built_r <= ~start_limit_build_sel_i; // RULE10
      else if (build_exp)
        built_r <= 1'b1; // RULE10
      torque_limit_o <= lim;
      limit_active_o <= active_now;
      at_limit_r <= active_now && torque_i >= lim;
      limit_prop_o <= active_now && !accel_limit_method_sel_i &&
        (accel_i | decel_i); // RULE8
      limit_integral_o <= active_now && (accel_limit_method_sel_i ||
        !(accel_i | decel_i)); // RULE9
      if (limit_integral_time_i < `TLG_INT_MIN_MS)
        limit_integral_time_o <= 14'd`TLG_INT_MIN_MS; // RULE7
      else if (limit_integral_time_i > `TLG_INT_MAX_MS)
        limit_integral_time_o <= 14'd`TLG_INT_MAX_MS;
      else
        limit_integral_time_o <= limit_integral_time_i;
      speed_ceiling_o <= ceil_c; // RULE17
      heatsink_overheat_alarm_o <= alarm_now; // RULE12
      if (hot_fault)
        heatsink_overheat_fault_o <= 1'b1; // RULE14
      else if (!run_i)
        heatsink_overheat_fault_o <= 1'b0;
      if (pl_enable && ripple_high_i)
        input_phase_loss_fault_o <= 1'b1; // RULE21
      else if (!run_i)
        input_phase_loss_fault_o <= 1'b0;
      ramp_stop_o <= alarm_now &&
        overheat_action_sel_i == `TLG_ACT_RAMP; // RULE15
      coast_stop_o <= (alarm_now &&
        overheat_action_sel_i == `TLG_ACT_COAST) || hot_fault ||
        (pl_enable && ripple_high_i) || fault_any; // RULE14
      fast_stop_o <= alarm_now && overheat_action_sel_i == `TLG_ACT_FAST;
      digital_out_o <= {
        do_bit(digital_output_function_c_i, at_limit_r, alarm_now,
          stopped_by_alarm | fault_any, maxed),
        do_bit(digital_output_function_b_i, at_limit_r, alarm_now,
          stopped_by_alarm | fault_any, maxed),
        do_bit(digital_output_function_a_i, at_limit_r, alarm_now,
          stopped_by_alarm | fault_any, maxed)};
    end
  end
endmodule
`default_nettype wire

/* dv/tlg_guard_asserts.sv */
// tlg_guard_asserts.sv: port-level checks of tlg_guard
// assumes bind from the bench top; settings steady within a test
`timescale 1ns/1ns
`default_nettype none
module tlg_guard_asserts #(
  parameter W = 9
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic accel_i,
  input wire logic decel_i,
  input wire logic [3:0] control_mode_i,
  input wire logic heavy_duty_rating_i,
  input wire logic accel_limit_method_sel_i,
  input wire logic start_limit_build_sel_i,
  input wire logic [W-1:0] current_i,
  input wire logic [7:0] heatsink_temp_i,
  input wire logic [7:0] overheat_alarm_level_i,
  input wire logic [2:0] overheat_action_sel_i,
  input wire logic [15:0] max_freq_i,
  input wire logic input_phase_loss_sel_i,
  input wire logic [W-1:0] torque_limit_o,
  input wire logic limit_active_o,
  input wire logic limit_prop_o,
  input wire logic limit_integral_o,
  input wire logic [13:0] limit_integral_time_o,
  input wire logic [15:0] speed_ceiling_o,
  input wire logic heatsink_overheat_alarm_o,
  input wire logic input_phase_loss_fault_o,
  input wire logic ramp_stop_o,
  input wire logic coast_stop_o,
  input wire logic fast_stop_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  AST_ALARM: assert property (
    heatsink_overheat_alarm_o ==
    ($past(heatsink_temp_i) > $past(overheat_alarm_level_i)))
    else $error("alarm level mismatch");
  AST_CAP: assert property (
    limit_active_o && $stable(heavy_duty_rating_i) |->
    torque_limit_o <= (heavy_duty_rating_i ? 9'h096 : 9'h078))
    else $error("limit above current cap");
  AST_MODE: assert property (
    limit_active_o |-> $past(control_mode_i) != 4'h0)
    else $error("limiting outside vector modes");
  AST_BUILD_ON: assert property (
    $rose(run_i) && start_limit_build_sel_i |-> !limit_active_o [*8])
    else $error("limit built too early");
  AST_BUILD_OFF: assert property (
    $rose(run_i) && !start_limit_build_sel_i && control_mode_i != 4'h0
    ##1 run_i [*3] |-> limit_active_o)
    else $error("limit late without build delay");
  AST_INT: assert property (
    limit_integral_time_o >= 14'h0005 && limit_integral_time_o <= 14'h2710)
    else $error("integral time out of range");
  AST_PI: assert property (
    limit_prop_o |-> !limit_integral_o && !$past(accel_limit_method_sel_i) &&
    ($past(accel_i) || $past(decel_i)))
    else $error("proportional action at wrong time");
  AST_HOLD: assert property (
    heatsink_overheat_alarm_o && overheat_action_sel_i == 3'h3 &&
    !input_phase_loss_fault_o |-> !(ramp_stop_o || coast_stop_o || fast_stop_o))
    else $error("stop in alarm-only action");
  AST_PL: assert property (
    $rose(input_phase_loss_fault_o) |-> $past(input_phase_loss_sel_i) &&
    $past(run_i) && !$past(decel_i) && $past(current_i) > 9'h01e)
    else $error("phase loss while gated");
  AST_REDUCE: assert property (
    $rose(heatsink_overheat_alarm_o) && overheat_action_sel_i == 3'h4 &&
    run_i |-> ##[1:3] speed_ceiling_o < max_freq_i)
    else $error("speed not reduced");
  cover property ($rose(limit_active_o));
  cover property ($rose(input_phase_loss_fault_o));
  cover property (limit_prop_o);
endmodule
`default_nettype wire

/* dv/tlg_plant.sv */
// tlg_plant.sv: power stage and heatsink sensor model
// assumes bench sets load, temperature and ripple; torque obeys limit
`timescale 1ns/1ns
`default_nettype none
module tlg_plant (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [8:0] load_i,
  input wire logic [8:0] limit_i,
  input wire logic [7:0] temp_set_i,
  input wire logic ripple_set_i,
  output logic [8:0] torque_o,
  output logic [8:0] current_o,
  output logic [7:0] temp_o,
  output logic ripple_o
);
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      torque_o <= 9'h000;
      current_o <= 9'h000;
      temp_o <= 8'h19;
      ripple_o <= 1'b0;
    end else begin
      // stage saturates at the commanded limit
      torque_o <= (load_i > limit_i) ? limit_i : load_i;
      current_o <= (load_i > limit_i) ? limit_i : load_i;
      temp_o <= temp_set_i;
      ripple_o <= ripple_set_i;
    end
  end
endmodule
`default_nettype wire

/* dv/tlg_guard_tb_top.sv */
// tlg_guard_tb_top.sv: self-checking bench for tlg_guard
// assumes tlg_plant and tlg_guard_asserts compiled first
`timescale 1ns/1ns
`default_nettype none
module tlg_guard_tb_top;
  logic clock_i = 1'b0, rst_n_i = 1'b0, run_i = 1'b0;
  logic accel_i = 1'b0, decel_i = 1'b0, heavy_duty_rating_i = 1'b1;
  logic accel_limit_method_sel_i = 1'b0, start_limit_build_sel_i = 1'b0;
  logic regen_limit_mode_sel_i = 1'b0, input_phase_loss_sel_i = 1'b1;
  logic [1:0] quadrant_i = 2'h0;
  logic [3:0] control_mode_i = 4'h1;
  logic [3:0] overheat_speed_reduction_factor_i = 4'h8;
  logic [13:0] limit_integral_time_i = 14'h00c8;
  logic [8:0] fwd_motoring_torque_limit_i = 9'h0c8;
  logic [8:0] rev_motoring_torque_limit_i = 9'h0c8;
  logic [8:0] fwd_regen_torque_limit_i = 9'h0c8;
  logic [8:0] rev_regen_torque_limit_i = 9'h0c8;
  logic [4:0] analog_input_function_a_i = 5'h00;
  logic [4:0] analog_input_function_b_i = 5'h00;
  logic [4:0] analog_input_function_c_i = 5'h00;
  logic [8:0] analog_a_i = 9'h000, analog_b_i = 9'h000, analog_c_i = 9'h000;
  logic [8:0] load = 9'h000;
  logic [7:0] temp_set = 8'h3c, overheat_alarm_level_i = 8'h50;
  logic [7:0] overheat_fault_level_i = 8'h78;
  logic [2:0] overheat_action_sel_i = 3'h3;
  logic [15:0] max_freq_i = 16'h03e8, base_freq_i = 16'h03e8;
  logic [5:0] digital_output_function_a_i = 6'h30;
  logic [5:0] digital_output_function_b_i = 6'h20;
  logic [5:0] digital_output_function_c_i = 6'h0e;
  logic ripple_set = 1'b0;
  logic [8:0] comm_limit_i = 9'h050;
  logic comm_limit_valid_i = 1'b0;
  wire [8:0] torque_i, current_i, torque_limit_o;
  wire [7:0] heatsink_temp_i;
  wire ripple_high_i, limit_active_o, limit_prop_o, limit_integral_o;
  wire heatsink_overheat_alarm_o, heatsink_overheat_fault_o;
  wire input_phase_loss_fault_o, ramp_stop_o, coast_stop_o, fast_stop_o;
  wire [13:0] limit_integral_time_o;
  wire [15:0] speed_ceiling_o;
  wire [2:0] digital_out_o;
  wire [2:0] stops = {fast_stop_o, coast_stop_o, ramp_stop_o};
  int errors = 0;
  int compares = 0;
  always #50 clock_i = ~clock_i;
  tlg_guard #(.TICK_CYCLES(10), .STEP_MS(3)) tlg_guard_inst (.*);
  tlg_plant tlg_plant_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .load_i(load), .limit_i(torque_limit_o), .temp_set_i(temp_set),
    .ripple_set_i(ripple_set), .torque_o(torque_i), .current_o(current_i),
    .temp_o(heatsink_temp_i), .ripple_o(ripple_high_i));
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    #1;
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
    @(posedge clock_i);
  endtask
  task chkb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task lq(input logic [1:0] q, input logic [8:0] e);
    quadrant_i <= q;
    cyc(3);
    chk("torque_limit", {7'h00, e}, {7'h00, torque_limit_o});
  endtask
  task pl(input logic s, d, r, input logic [8:0] l, input logic e);
    run_i <= 1'b0;
    ripple_set <= 1'b0;
    cyc(3);
    input_phase_loss_sel_i <= s;
    decel_i <= d;
    load <= l;
    run_i <= r;
    cyc(3);
    ripple_set <= 1'b1;
    cyc(5);
    chkb("phase_loss", e, input_phase_loss_fault_o);
  endtask
  task end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    cyc(4);
    chk("torque_limit", 16'h00c8, {7'h00, torque_limit_o});
    chk("int_time", 16'h00c8, {2'h0, limit_integral_time_o});
    cyc(2);
    rst_n_i <= 1'b1;
    fwd_motoring_torque_limit_i <= 9'h082;
    analog_input_function_a_i <= 5'h15;
    analog_a_i <= 9'h08c;
    run_i <= 1'b1;
    cyc(4);
    lq(2'h0, 9'h082);
    lq(2'h1, 9'h08c);
    lq(2'h3, 9'h08c);
    analog_input_function_a_i <= 5'h10;
    analog_a_i <= 9'h064;
    lq(2'h0, 9'h064);
    lq(2'h1, 9'h096);
    comm_limit_valid_i <= 1'b1;
    lq(2'h1, 9'h050);
    analog_input_function_a_i <= 5'h15;
    analog_a_i <= 9'h032;
    regen_limit_mode_sel_i <= 1'b1;
    lq(2'h2, 9'h096);
    analog_input_function_b_i <= 5'h12;
    analog_b_i <= 9'h046;
    lq(2'h2, 9'h046);
    heavy_duty_rating_i <= 1'b0;
    analog_b_i <= 9'h082;
    lq(2'h3, 9'h078);
    regen_limit_mode_sel_i <= 1'b0;
    load <= 9'h12c;
    cyc(4);
    chkb("at_limit_out", 1'b1, digital_out_o[0]);
    load <= 9'h000;
    control_mode_i <= 4'h0;
    cyc(4);
    chkb("at_limit_out", 1'b0, digital_out_o[0]);
    chkb("limit_active", 1'b0, limit_active_o);
    for (int i = 0; i < 4; i++) begin
      control_mode_i <= 4'h1 << i;
      cyc(3);
      chkb("limit_active", 1'b1, limit_active_o);
    end
    limit_integral_time_i <= 14'h0003;
    cyc(3);
    chk("int_time", 16'h0005, {2'h0, limit_integral_time_o});
    limit_integral_time_i <= 14'h3e80;
    accel_i <= 1'b1;
    cyc(3);
    chk("int_time", 16'h2710, {2'h0, limit_integral_time_o});
    chkb("prop", 1'b1, limit_prop_o);
    accel_limit_method_sel_i <= 1'b1;
    cyc(3);
    chkb("prop", 1'b0, limit_prop_o);
    chkb("integral", 1'b1, limit_integral_o);
    accel_i <= 1'b0;
    accel_limit_method_sel_i <= 1'b0;
    cyc(3);
    chkb("integral", 1'b1, limit_integral_o);
    $display("limit tests done");
    run_i <= 1'b0;
    start_limit_build_sel_i <= 1'b1;
    cyc(3);
    run_i <= 1'b1;
    cyc(20);
    chkb("limit_active", 1'b0, limit_active_o);
    cyc(650);
    chkb("limit_active", 1'b1, limit_active_o);
    temp_set <= 8'h50;
    cyc(4);
    chkb("alarm", 1'b0, heatsink_overheat_alarm_o);
    temp_set <= 8'h5a;
    cyc(4);
    chkb("alarm", 1'b1, heatsink_overheat_alarm_o);
    chkb("prealarm_out", 1'b1, digital_out_o[1]);
    chk("stops", 16'h0000, {13'h0000, stops});
    for (int a = 0; a < 3; a++) begin
      run_i <= 1'b0;
      temp_set <= 8'h3c;
      cyc(3);
      overheat_action_sel_i <= a[2:0];
      run_i <= 1'b1;
      cyc(3);
      temp_set <= 8'h5a;
      cyc(4);
      chk("stops", 16'h0001 << a, {13'h0000, stops});
      chkb("fault_out", 1'b1, digital_out_o[2]);
    end
    run_i <= 1'b0;
    temp_set <= 8'h3c;
    cyc(3);
    overheat_action_sel_i <= 3'h4;
    digital_output_function_a_i <= 6'h4d;
    run_i <= 1'b1;
    cyc(3);
    temp_set <= 8'h5a;
    cyc(15);
    chk("ceiling", 16'h0320, speed_ceiling_o);
    cyc(35);
    chk("ceiling", 16'h0280, speed_ceiling_o);
    chkb("reduce_max_out", 1'b0, digital_out_o[0]);
    cyc(300);
    chkb("reduce_max_out", 1'b1, digital_out_o[0]);
    temp_set <= 8'h3c;
    cyc(420);
    chk("ceiling", 16'h03e8, speed_ceiling_o);
    temp_set <= 8'h82;
    cyc(4);
    chkb("oh_fault", 1'b1, heatsink_overheat_fault_o);
    chkb("stop", 1'b1, |stops);
    $display("overheat tests done");
    run_i <= 1'b0;
    temp_set <= 8'h3c;
    start_limit_build_sel_i <= 1'b0;
    cyc(3);
    overheat_action_sel_i <= 3'h3;
    pl(1'b1, 1'b0, 1'b1, 9'h01f, 1'b1);
    pl(1'b0, 1'b0, 1'b1, 9'h01f, 1'b0);
    pl(1'b1, 1'b1, 1'b1, 9'h01f, 1'b0);
    pl(1'b1, 1'b0, 1'b0, 9'h01f, 1'b0);
    pl(1'b1, 1'b0, 1'b1, 9'h01e, 1'b0);
    $display("phase loss tests done");
    end_of_test;
  end
  initial begin
    cyc(20000);
    errors++;
    end_of_test;
  end
endmodule
bind tlg_guard tlg_guard_asserts #(.W(W)) tlg_guard_asserts_inst (.*);
`default_nettype wire
